//--- rtl/rwl_pkg.sv
// Constants and register layout for the reset, wake and bus transceiver control block.
package rwl_pkg;
  // System clock period in nanoseconds (40 MHz).
  localparam int RWL_CLK_NS = 25;
  // Reset pulse time held on the reset pin after an internal event ends.
  localparam int RWL_T_RST_NS = 1250000;
  // Reset pulse in clock cycles, nominal figure.
  localparam int RWL_RST_CYC = RWL_T_RST_NS / RWL_CLK_NS;
  // Width of the reset pulse counter, wide enough for the default count.
  localparam int RWL_RST_W = 17;
  // Least dominant time that qualifies a wake-up; value is a plain default.
  localparam int RWL_T_FILT_NS = 100000;
  // Filter length in cycles, rounded up because it is a least time.
  localparam int RWL_FILT_CYC = (RWL_T_FILT_NS + RWL_CLK_NS - 1) / RWL_CLK_NS;
  // Width of the dominant filter counter.
  localparam int RWL_FILT_W = 12;
  // Time in current limitation before the transmitter is shut off; plain default.
  localparam int RWL_T_CL_NS = 50000;
  // Current limit delay in cycles, rounded down because it is a longest time.
  localparam int RWL_CL_CYC = RWL_T_CL_NS / RWL_CLK_NS;
  // Width of the current limit counter.
  localparam int RWL_CL_W = 12;

  // Register offsets on the internal register port.
  localparam logic [4:0] RWL_OFS_MASK = 5'h09;
  localparam logic [4:0] RWL_OFS_IFLAG = 5'h0A;
  localparam logic [4:0] RWL_OFS_STAT = 5'h0B;
  localparam logic [4:0] RWL_OFS_CTRL = 5'h0C;
  localparam logic [4:0] RWL_OFS_RSR = 5'h0D;

  // Field positions in the reset cause status register.
  localparam int RWL_B_POR = 0;
  localparam int RWL_B_PIN = 1;
  localparam int RWL_B_WD = 2;
  localparam int RWL_B_HT = 3;
  localparam int RWL_B_LV = 4;
  localparam int RWL_B_LINW = 5;
  localparam int RWL_B_WAKEW = 6;
  // Mask register fields.
  localparam int RWL_B_OVERTEMP_RESET_DISABLE = 4;
  localparam int RWL_B_BUS_WAKE_IRQ_ENABLE = 5;
  // Interrupt flag register field.
  localparam int RWL_B_BUS_WAKE_IRQ_FLAG = 5;
  // System control fields.
  localparam int RWL_B_PSE = 0;
  localparam int RWL_B_SRS = 1;
  // System state fields.
  localparam int RWL_B_CL = 0;
  localparam int RWL_B_CLOFF = 1;

  // Values after reset.
  localparam logic [7:0] RWL_RSR_POR = 8'h01;
  localparam logic [7:0] RWL_REG_RST = 8'h00;
  // Slew rate codes; the reset value suits 20 kbit/s.
  localparam logic [1:0] RWL_SRS_10K = 2'h0;
  localparam logic [1:0] RWL_SRS_20K = 2'h1;
  localparam logic [1:0] RWL_SRS_FAST = 2'h2;
  localparam logic [7:0] RWL_CTRL_RST = {5'h00, RWL_SRS_20K, 1'b0};

  // Synchroniser order and idle levels: curlim,txd,sleep,stop,wake,rx,rstpin,vlow,wd,ot.
  // Pin asserted-high inputs idle low; reset pin, bus level and transmit idle high.
  localparam logic [9:0] RWL_SYNC_RST = 10'h118;
  localparam int RWL_S_OT = 0;
  localparam int RWL_S_WD = 1;
  localparam int RWL_S_VLOW = 2;
  localparam int RWL_S_RPIN = 3;
  localparam int RWL_S_RX = 4;
  localparam int RWL_S_WAKE = 5;
  localparam int RWL_S_STOP = 6;
  localparam int RWL_S_SLEEP = 7;
  localparam int RWL_S_TXD = 8;
  localparam int RWL_S_CLIM = 9;
  // Cycles the own reset drive is remembered, covering the pin input latency.
  localparam logic [2:0] RWL_DRV_HIST_RST = 3'h7;
endpackage : rwl_pkg

//--- rtl/rwl_reset_wake_ctrl.sv
// Reset cause, wake-up and bus transceiver control of the analog die.
`timescale 1ns/10ps
module rwl_reset_wake_ctrl import rwl_pkg::*; #(
  parameter int unsigned RST_PULSE_CYC = RWL_RST_CYC
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic OVERTEMP,
  input wire logic WDOG_FAULT,
  input wire logic VDD_LOW,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE,
  input wire logic STOP_MODE,
  input wire logic SLEEP_MODE,
  input wire logic WAKE_PIN,
  input wire logic TXD,
  output logic TXD_PULLUP_EN,
  output logic RXD,
  input wire logic LIN_RX,
  input wire logic LIN_CURLIM,
  output logic LIN_DOM_O,
  output logic LIN_PULLUP_EN,
  output logic LIN_WEAK_SRC_EN,
  output logic [1:0] SLEW_RATE,
  output logic BUS_WAKE_IRQ
);
  // Two-stage synchroniser for all pin inputs.
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  // Register file.
  logic [7:0] rsr_r; // Reset cause status, survives internal resets.
  logic [7:0] mask_r; // Overtemp disable and bus wake interrupt enable.
  logic [7:0] iflag_r; // Bus wake interrupt flag.
  logic [7:0] ctrl_r; // Power stage enable and slew select.
  logic [7:0] stat_r; // Current limit flags.
  logic [7:0] rdata_r;
  // Reset pulse machinery.
  logic [RWL_RST_W-1:0] pulse_cnt_r;
  logic [RWL_RST_W-1:0] pulse_cnt_nxt;
  logic drive_r;
  logic [2:0] drv_hist_r;
  // Transceiver outputs.
  logic lin_dom_r;
  logic rxd_r;
  logic pullup_r;
  logic weak_r;
  logic irq_r;
  logic [RWL_CL_W-1:0] cl_cnt_r;
  // Wake input reference level.
  logic wake_ref_r;
  // Decoded events.
  logic ot_s, wd_s, vlow_s, rpin_s, rx_s, wake_s;
  logic stop_s, sleep_s, txd_s, clim_s;
  logic ht_req, lin_sleep_wake, lin_stop_wake, wake_in_evt, int_src;
  logic pin_evt, lowpwr;
  logic [7:0] rsr_set;
  logic wr_rsr, wr_mask, wr_iflag, wr_ctrl, wr_stat;

  // Clears only where a one is written and no new event sets the bit.
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic wr, input logic [7:0] wd);
    w1c = (cur & ~(wr ? wd : 8'h00)) | set;
  endfunction : w1c

  // Filter carrier and instance.
  rwl_wake_if wk ();
  rwl_wake_filter u_filt (
    .clk(CLK_SYS),
    .nrst(NRST),
    .wk(wk.filt)
  );

  // Every pin input passes two flops; only the second stage is read.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sync1_r <= RWL_SYNC_RST;
      sync2_r <= RWL_SYNC_RST;
    end else begin
      sync1_r <= {LIN_CURLIM, TXD, SLEEP_MODE, STOP_MODE, WAKE_PIN,
                  LIN_RX, RST_PIN_I, VDD_LOW, WDOG_FAULT, OVERTEMP};
      sync2_r <= sync1_r;
    end
  end

  assign ot_s = sync2_r[RWL_S_OT];
  assign wd_s = sync2_r[RWL_S_WD];
  assign vlow_s = sync2_r[RWL_S_VLOW];
  assign rpin_s = sync2_r[RWL_S_RPIN];
  assign rx_s = sync2_r[RWL_S_RX];
  assign wake_s = sync2_r[RWL_S_WAKE];
  assign stop_s = sync2_r[RWL_S_STOP];
  assign sleep_s = sync2_r[RWL_S_SLEEP];
  assign txd_s = sync2_r[RWL_S_TXD];
  assign clim_s = sync2_r[RWL_S_CLIM];
  assign lowpwr = stop_s || sleep_s;

  assign wk.rx_level = rx_s;
  assign wk.armed = lowpwr;

  // Overtemperature reset unless the test-only disable bit is set.
  assign ht_req = ot_s && !mask_r[RWL_B_OVERTEMP_RESET_DISABLE];
  // Sleep wins over Stop if both are reported.
  assign lin_sleep_wake = wk.wake_pulse && sleep_s;
  assign lin_stop_wake = wk.wake_pulse && stop_s && !sleep_s
                         && mask_r[RWL_B_BUS_WAKE_IRQ_ENABLE];
  assign wake_in_evt = sleep_s && (wake_s != wake_ref_r);
  // All internal reset causes, any of which restarts the pulse.
  assign int_src = ht_req || wd_s || vlow_s || lin_sleep_wake || wake_in_evt;
  // A low pin counts as external only when our own drive is long gone.
  assign pin_evt = !rpin_s && !drive_r && (drv_hist_r == 3'h0);

  // Every cause present this cycle sets its own bit.
  always_comb begin
    rsr_set = 8'h00;
    rsr_set[RWL_B_HT] = ht_req;
    rsr_set[RWL_B_WD] = wd_s;
    rsr_set[RWL_B_LV] = vlow_s;
    rsr_set[RWL_B_PIN] = pin_evt;
    rsr_set[RWL_B_LINW] = lin_sleep_wake;
    rsr_set[RWL_B_WAKEW] = wake_in_evt;
  end

  // Address decode for single-cycle writes.
  assign wr_rsr = REG_WR && (REG_ADDR == RWL_OFS_RSR);
  assign wr_mask = REG_WR && (REG_ADDR == RWL_OFS_MASK);
  assign wr_iflag = REG_WR && (REG_ADDR == RWL_OFS_IFLAG);
  assign wr_ctrl = REG_WR && (REG_ADDR == RWL_OFS_CTRL);
  assign wr_stat = REG_WR && (REG_ADDR == RWL_OFS_STAT);

  // Cause status: power-on leaves only the power-on bit, set beats clear.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rsr_r <= RWL_RSR_POR;
    end else begin
      rsr_r <= w1c(rsr_r, rsr_set, wr_rsr, REG_WDATA) & 8'h7F;
    end
  end

  // Mask register, cleared by any internal reset.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mask_r <= RWL_REG_RST;
    end else if (drive_r) begin
      mask_r <= RWL_REG_RST;
    end else if (wr_mask) begin
      mask_r <= REG_WDATA;
    end
  end

  // Bus wake interrupt flag, write one to clear.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      iflag_r <= RWL_REG_RST;
    end else if (drive_r) begin
      iflag_r <= RWL_REG_RST;
    end else begin
      iflag_r <= w1c(iflag_r, {2'h0, lin_stop_wake, 5'h00}, wr_iflag, REG_WDATA)
                 & 8'h20;
    end
  end

  // System control; the slew field leaves reset at the 20 kbit/s code.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl_r <= RWL_CTRL_RST;
    end else if (drive_r) begin
      ctrl_r <= RWL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= REG_WDATA & 8'h07;
    end
  end

  // Current limit flag and shutdown latch; the latch clears with the enable.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      stat_r <= RWL_REG_RST;
    end else if (drive_r) begin
      stat_r <= RWL_REG_RST;
    end else begin
      stat_r[RWL_B_CL] <= clim_s || (stat_r[RWL_B_CL]
                          && !(wr_stat && REG_WDATA[RWL_B_CL]));
      stat_r[RWL_B_CLOFF] <= ctrl_r[RWL_B_PSE] && (stat_r[RWL_B_CLOFF]
                             || cl_cnt_r == RWL_CL_W'(RWL_CL_CYC));
    end
  end

  // Time spent in current limitation; drops back when the limit ends.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cl_cnt_r <= '0;
    end else if (!clim_s || !ctrl_r[RWL_B_PSE]) begin
      cl_cnt_r <= '0;
    end else if (cl_cnt_r != RWL_CL_W'(RWL_CL_CYC)) begin
      cl_cnt_r <= cl_cnt_r + RWL_CL_W'(1);
    end
  end

  // Read data is registered, so it answers one cycle after the address.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= 8'h00;
    end else begin
      case (REG_ADDR)
        RWL_OFS_RSR: rdata_r <= rsr_r;
        RWL_OFS_MASK: rdata_r <= mask_r;
        RWL_OFS_IFLAG: rdata_r <= iflag_r;
        RWL_OFS_CTRL: rdata_r <= ctrl_r;
        RWL_OFS_STAT: rdata_r <= stat_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // Pulse counter reloads while a cause lasts, then runs out.
  always_comb begin
    if (int_src) begin
      pulse_cnt_nxt = RWL_RST_W'(RST_PULSE_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_nxt = pulse_cnt_r - RWL_RST_W'(1);
    end else begin
      pulse_cnt_nxt = '0;
    end
  end

  // Power-on starts with a full pulse; low supply keeps reloading it.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pulse_cnt_r <= RWL_RST_W'(RST_PULSE_CYC);
      drive_r <= 1'b1;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
      drive_r <= int_src || (pulse_cnt_nxt != '0);
    end
  end

  // Remembers recent own drive while the pin input catches up.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      drv_hist_r <= RWL_DRV_HIST_RST;
    end else begin
      drv_hist_r <= {drv_hist_r[1:0], drive_r};
    end
  end

  // Wake input level is taken every cycle; a change while in Sleep is one event.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wake_ref_r <= 1'b0;
    end else begin
      wake_ref_r <= wake_s;
    end
  end

  // Transmitter: enabled, awake, not shut off, and transmit input low.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lin_dom_r <= 1'b0;
    end else begin
      lin_dom_r <= ctrl_r[RWL_B_PSE] && !lowpwr && !stat_r[RWL_B_CLOFF]
                   && !txd_s;
    end
  end

  // Receive pin mirrors the bus; pull-up swaps for weak source in low power.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rxd_r <= 1'b1;
      pullup_r <= 1'b1;
      weak_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rxd_r <= rx_s;
      pullup_r <= !lowpwr;
      weak_r <= lowpwr;
      irq_r <= iflag_r[RWL_B_BUS_WAKE_IRQ_FLAG] && mask_r[RWL_B_BUS_WAKE_IRQ_ENABLE];
    end
  end

  assign REG_RDATA = rdata_r;
  assign RST_PIN_O = 1'b0; // Open drain: the pin is only ever pulled low.
  assign RST_PIN_OE = drive_r;
  assign TXD_PULLUP_EN = 1'b1;
  assign RXD = rxd_r;
  assign LIN_DOM_O = lin_dom_r;
  assign LIN_PULLUP_EN = pullup_r;
  assign LIN_WEAK_SRC_EN = weak_r;
  assign SLEW_RATE = ctrl_r[RWL_B_SRS+:2];
  assign BUS_WAKE_IRQ = irq_r;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_ht_reset_flag: assert property (ht_req |=> rsr_r[RWL_B_HT] && drive_r)
    else $error("Overtemperature did not flag and reset.");
  a_ht_disabled: assert property (ot_s && mask_r[RWL_B_OVERTEMP_RESET_DISABLE] && !rsr_r[RWL_B_HT]
    |=> !rsr_r[RWL_B_HT]) else $error("Overtemperature flagged while disabled.");
  a_wd_flag: assert property (wd_s |=> rsr_r[RWL_B_WD] && drive_r)
    else $error("Watchdog fault not flagged.");
  a_lv_flag: assert property (vlow_s |=> rsr_r[RWL_B_LV] && RST_PIN_OE)
    else $error("Low voltage did not pull reset.");
  a_soft_clear: assert property (drive_r |=> ctrl_r == RWL_CTRL_RST
    && mask_r == RWL_REG_RST) else $error("Registers kept through reset.");
  a_pulse_hold: assert property ($fell(int_src) |-> drive_r [*8])
    else $error("Reset pin released too early.");
  a_w1c_clear: assert property (wr_rsr && REG_WDATA[RWL_B_POR]
    |=> !rsr_r[RWL_B_POR]) else $error("Power-on flag not cleared.");
  a_set_wins: assert property (wr_rsr && REG_WDATA[RWL_B_WD] && wd_s
    |=> rsr_r[RWL_B_WD]) else $error("Set lost to a clear.");
  a_keep_zero: assert property (wr_rsr && !REG_WDATA[RWL_B_POR] && rsr_r[RWL_B_POR]
    |=> rsr_r[RWL_B_POR]) else $error("Zero write cleared a flag.");
  a_multi_cause: assert property (wd_s && ht_req |=> rsr_r[RWL_B_WD]
    && rsr_r[RWL_B_HT]) else $error("Simultaneous causes not all set.");
  a_sleep_wake: assert property (lin_sleep_wake |=> rsr_r[RWL_B_LINW]
    && drive_r) else $error("Sleep wake did not reset.");
  a_stop_irq: assert property (lin_stop_wake |=> ##1 BUS_WAKE_IRQ)
    else $error("Stop wake did not interrupt.");
  a_tx_gate: assert property (!ctrl_r[RWL_B_PSE] || lowpwr
    |=> !LIN_DOM_O) else $error("Transmitter active while gated.");
  a_tx_follow: assert property (ctrl_r[RWL_B_PSE] && !lowpwr && !stat_r[RWL_B_CLOFF]
    |=> LIN_DOM_O == !$past(txd_s)) else $error("Bus does not follow transmit.");
  a_rx_follow: assert property (##1 RXD == $past(rx_s))
    else $error("Receive pin lags bus.");
  a_cl_flag: assert property (clim_s && !drive_r |=> stat_r[RWL_B_CL])
    else $error("Current limit not flagged.");
endmodule : rwl_reset_wake_ctrl

//--- rtl/rwl_wake_filter.sv
// Dominant-duration filter that qualifies bus wake-up patterns.
`timescale 1ns/10ps
module rwl_wake_filter import rwl_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  rwl_wake_if.filt wk
);
  // Counts dominant cycles, saturating at the filter length.
  logic [RWL_FILT_W-1:0] cnt_r;
  // Previous bus level, for the rising edge.
  logic prev_r;
  // Filter time has passed in the current dominant phase.
  logic expired;
  // Registered wake pulse.
  logic pulse_r;

  assign expired = (cnt_r == RWL_FILT_W'(RWL_FILT_CYC));
  assign wk.wake_pulse = pulse_r;

  // A recessive level restarts the count, so short glitches never add up.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (wk.rx_level || !wk.armed) begin
      cnt_r <= '0;
    end else if (!expired) begin
      cnt_r <= cnt_r + RWL_FILT_W'(1);
    end
  end

  // Edge memory resets recessive so that no edge is seen out of reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= wk.rx_level;
    end
  end

  // Only a rising edge after an expired dominant phase wakes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= wk.armed && wk.rx_level && !prev_r && expired;
    end
  end

  a_filt_qualify: assert property (@(posedge clk) disable iff (!nrst)
    pulse_r |-> $past(expired) && $past(wk.rx_level) && !$past(prev_r))
    else $error("Wake pulse without a qualified dominant phase.");
endmodule : rwl_wake_filter

//--- rtl/rwl_wake_if.sv
// Carrier between the control block and its bus wake-up filter.
`timescale 1ns/10ps
interface rwl_wake_if;
  logic rx_level; // Synchronised bus level, high is recessive.
  logic armed; // High in Stop or Sleep, when wake patterns count.
  logic wake_pulse; // One-cycle pulse on a qualified wake pattern.
  modport filt (input rx_level, input armed, output wake_pulse);
  modport ctrl (output rx_level, output armed, input wake_pulse);
endinterface : rwl_wake_if

//--- tb/reset_wake_and_lin_control_tb.sv
// Self-checking testbench for the reset, wake and bus transceiver control block.
`timescale 1ns/10ps
module reset_wake_and_lin_control_tb import rwl_pkg::*;;
  // Short reset pulse keeps the run brief; every pulse-length expectation derives from it.
  localparam int unsigned PULSE = 20;
  // One row: causes {pin, vlow, wd, ot} and the cause flags they should leave.
  typedef struct {logic [3:0] cause; logic [7:0] reset_cause_status;} rwl_row_s;
  rwl_row_s rows [5] = '{'{4'b0010, 8'h04}, '{4'b0001, 8'h08}, '{4'b0100, 8'h10},
    '{4'b1000, 8'h02}, '{4'b0011, 8'h0C}};
  logic clk_sys, nrst, reg_wr, overtemp, wdog_fault, vdd_low, ext_rst, stop_mode;
  logic sleep_mode, wake_pin, txd, remote_dom, overload;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic rst_pin_o, rst_pin_oe, txd_pullup_en, rxd, lin_rx, lin_curlim, lin_dom_o;
  wire logic lin_pullup_en, lin_weak_src_en, bus_wake_irq;
  wire logic [1:0] slew_rate;
  // Open-drain reset wire: low when the device or an outside party pulls it.
  wire logic rst_pin_lvl = !(rst_pin_oe || ext_rst);
  int n_errors = 0;
  int n_checks = 0;
  int n_cyc = 0;
  int n;

  rwl_reset_wake_ctrl #(.RST_PULSE_CYC(PULSE)) dut (.CLK_SYS(clk_sys), .NRST(nrst),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .OVERTEMP(overtemp), .WDOG_FAULT(wdog_fault), .VDD_LOW(vdd_low), .RST_PIN_I(rst_pin_lvl),
    .RST_PIN_O(rst_pin_o), .RST_PIN_OE(rst_pin_oe), .STOP_MODE(stop_mode),
    .SLEEP_MODE(sleep_mode), .WAKE_PIN(wake_pin), .TXD(txd), .TXD_PULLUP_EN(txd_pullup_en),
    .RXD(rxd), .LIN_RX(lin_rx), .LIN_CURLIM(lin_curlim), .LIN_DOM_O(lin_dom_o),
    .LIN_PULLUP_EN(lin_pullup_en), .LIN_WEAK_SRC_EN(lin_weak_src_en), .SLEW_RATE(slew_rate),
    .BUS_WAKE_IRQ(bus_wake_irq));

  rwl_lin_bus_model bus (.dom_o(lin_dom_o), .pullup_en(lin_pullup_en),
    .weak_en(lin_weak_src_en), .remote_dom(remote_dom), .overload(overload),
    .lin_rx(lin_rx), .curlim(lin_curlim));

  // Free-running system clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Compares a seen value with the expected one and reports any difference.
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // The whole run should take about 10600 cycles; a hang is cut off well past that.
  always @(posedge clk_sys) begin
    n_cyc++;
    if (n_cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  task cyc(int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc

  // One-cycle write strobe; a gap cycle always follows, so strobes never merge.
  task wr(logic [4:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled one cycle after the address.
  task rdc(string what, logic [4:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    check(what, reg_rdata, exp);
  endtask : rdc

  // Counts cycles until the device lets go of the reset pin, bounded.
  task wait_oe_low(output int k);
    k = 0;
    while (rst_pin_oe === 1'b1 && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : wait_oe_low

  initial begin
    {nrst, reg_wr, overtemp, wdog_fault, vdd_low, ext_rst, stop_mode} = 7'h00;
    {sleep_mode, wake_pin, remote_dom, overload} = 4'h0;
    txd = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (20) @(negedge clk_sys);
    check("oe in reset", rst_pin_oe, 1'b1);
    check("slew in reset", slew_rate, RWL_SRS_20K);
    nrst = 1'b1;
    wait_oe_low(n);
    check("power-up pulse", n >= PULSE - 1 && n <= PULSE + 4, 1'b1);
    cyc(5);
    rdc("rsr power-on", RWL_OFS_RSR, RWL_RSR_POR);
    wr(RWL_OFS_RSR, 8'h00);
    rdc("rsr write zero", RWL_OFS_RSR, RWL_RSR_POR);
    wr(RWL_OFS_RSR, 8'h01);
    rdc("rsr write one", RWL_OFS_RSR, 8'h00);
    rdc("unmapped", 5'h1F, 8'h00);
    check("txd pull-up", txd_pullup_en, 1'b1);
    check("rst pin drive", rst_pin_o, 1'b0);
    // Ordinary reset causes, one per row and a watchdog plus overtemperature pair last; flags for each, pulse for all but the pin.
    foreach (rows[i]) begin
      wr(RWL_OFS_RSR, 8'hFF);
      wr(RWL_OFS_CTRL, 8'h05);
      {ext_rst, vdd_low, wdog_fault, overtemp} = rows[i].cause;
      cyc(6);
      if (!rows[i].cause[3]) check("oe on cause", rst_pin_oe, 1'b1);
      {ext_rst, vdd_low, wdog_fault, overtemp} = 4'h0;
      wait_oe_low(n);
      if (!rows[i].cause[3]) begin
        check("pulse after cause", n >= PULSE && n <= PULSE + 6, 1'b1);
        rdc("ctrl after reset", RWL_OFS_CTRL, RWL_CTRL_RST);
      end
      cyc(5);
      rdc("rsr cause", RWL_OFS_RSR, rows[i].reset_cause_status);
    end
    // A clear written while the watchdog cause still stands must lose to the set.
    wdog_fault = 1'b1;
    cyc(4);
    wr(RWL_OFS_RSR, 8'hFF);
    wdog_fault = 1'b0;
    wait_oe_low(n);
    cyc(5);
    rdc("set beats clear", RWL_OFS_RSR, 8'h04);
    // A disabled overtemperature reset must neither pull the pin nor set its flag.
    wr(RWL_OFS_RSR, 8'hFF);
    wr(RWL_OFS_MASK, 8'h10);
    overtemp = 1'b1;
    cyc(8);
    check("oe disabled", rst_pin_oe, 1'b0);
    overtemp = 1'b0;
    cyc(4);
    rdc("rsr disabled", RWL_OFS_RSR, 8'h00);
    wr(RWL_OFS_MASK, 8'h00);
    // Transmitter gating, transmit following and receive reporting.
    txd = 1'b0;
    cyc(4);
    check("dom without enable", lin_dom_o, 1'b0);
    check("rxd recessive", rxd, 1'b1);
    wr(RWL_OFS_CTRL, 8'h03);
    cyc(4);
    check("dom enabled", lin_dom_o, 1'b1);
    check("rxd dominant", rxd, 1'b0);
    txd = 1'b1;
    cyc(4);
    check("dom released", lin_dom_o, 1'b0);
    remote_dom = 1'b1;
    cyc(4);
    check("rxd remote", rxd, 1'b0);
    remote_dom = 1'b0;
    for (int c = 0; c < 3; c++) begin
      wr(RWL_OFS_CTRL, {5'h00, c[1:0], 1'b1});
      cyc(2);
      check("slew code", slew_rate, c[1:0]);
    end
    // Current limit: flag at once, shutdown after the fixed delay.
    txd = 1'b0;
    overload = 1'b1;
    cyc(6);
    rdc("limit flag", RWL_OFS_STAT, 8'h01);
    cyc(2000);
    check("limit shutdown", lin_dom_o, 1'b0);
    rdc("limit latch", RWL_OFS_STAT, 8'h03);
    overload = 1'b0;
    txd = 1'b1;
    wr(RWL_OFS_CTRL, 8'h02);
    wr(RWL_OFS_STAT, 8'h01);
    rdc("limit cleared", RWL_OFS_STAT, 8'h00);
    // Stop: weak source, no transmitter, filtered wake interrupt.
    wr(RWL_OFS_CTRL, 8'h03);
    wr(RWL_OFS_MASK, 8'h20);
    stop_mode = 1'b1;
    txd = 1'b0;
    cyc(4);
    check("pull-up off", lin_pullup_en, 1'b0);
    check("weak source on", lin_weak_src_en, 1'b1);
    check("dom in stop", lin_dom_o, 1'b0);
    txd = 1'b1;
    remote_dom = 1'b1;
    cyc(100);
    remote_dom = 1'b0;
    cyc(8);
    check("short pulse", bus_wake_irq, 1'b0);
    remote_dom = 1'b1;
    cyc(4010);
    remote_dom = 1'b0;
    cyc(8);
    check("stop wake irq", bus_wake_irq, 1'b1);
    rdc("iflag", RWL_OFS_IFLAG, 8'h20);
    wr(RWL_OFS_IFLAG, 8'h20);
    cyc(3);
    check("irq cleared", bus_wake_irq, 1'b0);
    stop_mode = 1'b0;
    wr(RWL_OFS_MASK, 8'h00);
    // Sleep: bus pattern, then wake input, each resets and flags its cause.
    wr(RWL_OFS_RSR, 8'hFF);
    sleep_mode = 1'b1;
    cyc(4);
    remote_dom = 1'b1;
    cyc(4010);
    remote_dom = 1'b0;
    cyc(6);
    sleep_mode = 1'b0;
    check("sleep wake reset", rst_pin_oe, 1'b1);
    wait_oe_low(n);
    cyc(5);
    rdc("bus wake flag", RWL_OFS_RSR, 8'h20);
    wr(RWL_OFS_RSR, 8'hFF);
    sleep_mode = 1'b1;
    cyc(4);
    wake_pin = 1'b1;
    cyc(6);
    sleep_mode = 1'b0;
    wait_oe_low(n);
    cyc(5);
    rdc("input wake flag", RWL_OFS_RSR, 8'h40);
    // A second power-on in mid-run clears the wake flag and sets only its own.
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    wait_oe_low(n);
    cyc(5);
    rdc("rsr second power-on", RWL_OFS_RSR, RWL_RSR_POR);
    finish_test();
  end
endmodule : reset_wake_and_lin_control_tb

//--- tb/rwl_lin_bus_model.sv
// Behavioural model of the single-wire bus, a second node on it and an overload fault.
`timescale 1ns/10ps
module rwl_lin_bus_model (
  input wire logic dom_o,
  input wire logic pullup_en,
  input wire logic weak_en,
  input wire logic remote_dom,
  input wire logic overload,
  output logic lin_rx,
  output logic curlim
);
  // The bus is recessive only while nobody pulls it and a pull-up or weak source holds it.
  // With neither source on, the wire floats to ground, so a missing source shows as dominant.
  assign lin_rx = !(dom_o || remote_dom) && (pullup_en || weak_en);
  // An overloaded line limits the driver's current only while the driver is on.
  assign curlim = dom_o && overload;
endmodule : rwl_lin_bus_model
